// [fsra_pkg.sv]
// Package of constants for the secured extra region host controller
package fsra_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 24'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 24'h0002AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_ENTER = 16'h0088;
    localparam logic [DATA_W-1:0] CMD_EXIT = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [ADDR_W-1:0] REGION_LAST = 24'h0000FF;
    localparam logic [ADDR_W-1:0] CUSTOMER_FIRST = 24'h000080;
    localparam logic [ADDR_W-1:0] ID_LOCK_ADDR = 24'h000003;
    localparam int FACTORY_LOCK_BIT = 7;
    localparam int CUSTOMER_LOCK_BIT = 6;
    localparam int CLK_PERIOD_NS = 10;
    // Bus write strobe low time, setup/hold and read access times
    localparam int WE_LOW_NS = 40;
    localparam int SETUP_NS = 20;
    localparam int READ_ACC_NS = 80;
    localparam int RESET_PULSE_MIN_WIDTH_NS = 30;
    localparam int RESET_RECOVER_NS = 200;
    localparam logic [7:0] WE_LOW_CYC = 8'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_CYC = 8'((READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RESET_CYC =
        8'((RESET_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RECOVER_CYC = 8'((RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    typedef enum logic [2:0] {
        FSRA_OP_READ, FSRA_OP_ENTER, FSRA_OP_EXIT, FSRA_OP_PROGRAM, FSRA_OP_LOCKRD, FSRA_OP_RESET
    } fsra_op_t;
endpackage

// [fsra_host.sv]
// Host controller driving the flash bus for secured extra region access
`timescale 1ns/1ps
module fsra_host
    import fsra_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic REQ_VALID,
    input wire fsra_op_t REQ_OP,
    input wire logic [7:0] REQ_OFFSET,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    input wire logic [ADDR_W-1:0] REQ_BASE,
    input wire logic FLASH_BUSY,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    output logic RSP_ERR,
    output logic IN_MODE,
    output logic FACTORY_LOCK_INDICATOR,
    output logic CUSTOMER_LOCK_INDICATOR,
    output logic [ADDR_W-1:0] FL_ADDR,
    output logic [DATA_W-1:0] FL_DQ_O,
    output logic FL_DQ_OE,
    input wire logic [DATA_W-1:0] FL_DQ_I,
    output logic FL_CE_N,
    output logic FL_WE_N,
    output logic FL_OE_N,
    output logic FL_RESET_N
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
    logic busy_s1_reg, busy_s2_reg, busy_s3_reg, busy_reg;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dq_s1_reg <= 16'h0000;
            dq_s2_reg <= 16'h0000;
            dq_s3_reg <= 16'h0000;
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            busy_s3_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else if (CLK_EN) begin
            dq_s1_reg <= FL_DQ_I;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
            busy_s1_reg <= FLASH_BUSY;
            busy_s2_reg <= busy_s1_reg;
            busy_s3_reg <= busy_s2_reg;
            if (busy_s2_reg == busy_s3_reg) begin
                busy_reg <= busy_s3_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FSRA_IDLE, FSRA_SETUP, FSRA_STROBE, FSRA_GAP, FSRA_READ, FSRA_RST, FSRA_RECOVER
    } fsra_state_t;

    fsra_state_t state_reg;
    fsra_op_t op_reg;
    logic [2:0] cyc_reg;
    logic [2:0] ncyc_reg;
    logic [7:0] cnt_reg;
    logic [7:0] off_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [ADDR_W-1:0] base_reg;

    function automatic logic [ADDR_W-1:0] cyc_addr(input logic [2:0] c, input fsra_op_t o,
                                                    input logic [ADDR_W-1:0] b,
                                                    input logic [7:0] off);
        if (c == 3'd1) begin
            cyc_addr = b + UNLOCK_ADDR2;
        end else if (c == 3'd3 || o == FSRA_OP_READ || o == FSRA_OP_LOCKRD) begin
            cyc_addr = (o == FSRA_OP_LOCKRD) ? b + ID_LOCK_ADDR : b + {16'h0000, off};
        end else begin
            cyc_addr = b + UNLOCK_ADDR1;
        end
    endfunction

    function automatic logic [DATA_W-1:0] cyc_data(input logic [2:0] c, input fsra_op_t o,
                                                    input logic [DATA_W-1:0] w);
        case (c)
            3'd0: cyc_data = UNLOCK_DATA1;
            3'd1: cyc_data = UNLOCK_DATA2;
            3'd2: cyc_data = (o == FSRA_OP_ENTER) ? CMD_ENTER :
                             (o == FSRA_OP_EXIT) ? CMD_EXIT : CMD_PROGRAM;
            default: cyc_data = w;
        endcase
    endfunction

    // Programs to factory half offsets or outside the entered region mode are refused here
    wire prog_bad = (REQ_OP == FSRA_OP_PROGRAM) &&
                    ({16'h0000, REQ_OFFSET} < CUSTOMER_FIRST || !IN_MODE);
    wire lock_bad = (REQ_OP == FSRA_OP_LOCKRD) && IN_MODE;
    wire req_take = REQ_VALID && REQ_READY;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg <= FSRA_RST;
            op_reg <= FSRA_OP_READ;
            cyc_reg <= 3'd0;
            ncyc_reg <= 3'd0;
            cnt_reg <= 8'h00;
            off_reg <= 8'h00;
            wdata_reg <= 16'h0000;
            base_reg <= 24'h000000;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_ERR <= 1'b0;
            RSP_RDATA <= 16'h0000;
            IN_MODE <= 1'b0;
            FACTORY_LOCK_INDICATOR <= 1'b0;
            CUSTOMER_LOCK_INDICATOR <= 1'b0;
            FL_ADDR <= 24'h000000;
            FL_DQ_O <= 16'h0000;
            FL_DQ_OE <= 1'b0;
            FL_CE_N <= 1'b1;
            FL_WE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            FL_RESET_N <= 1'b0;
        end else if (CLK_EN) begin
            RSP_VALID <= 1'b0;
            case (state_reg)
                FSRA_IDLE: begin
                    if (req_take) begin
                        REQ_READY <= 1'b0;
                        op_reg <= REQ_OP;
                        off_reg <= REQ_OFFSET;
                        wdata_reg <= REQ_WDATA;
                        base_reg <= REQ_BASE;
                        cnt_reg <= 8'h00;
                        if (REQ_OP == FSRA_OP_RESET) begin
                            FL_RESET_N <= 1'b0;
                            state_reg <= FSRA_RST;
                        end else if (prog_bad || lock_bad || busy_reg) begin
                            RSP_VALID <= 1'b1;
                            RSP_ERR <= 1'b1;
                            REQ_READY <= 1'b1;
                        end else if (REQ_OP == FSRA_OP_READ || REQ_OP == FSRA_OP_LOCKRD) begin
                            cyc_reg <= 3'd3;
                            FL_ADDR <= cyc_addr(3'd3, REQ_OP, REQ_BASE, REQ_OFFSET);
                            FL_CE_N <= 1'b0;
                            FL_OE_N <= 1'b0;
                            state_reg <= FSRA_READ;
                        end else begin
                            cyc_reg <= 3'd0;
                            ncyc_reg <= (REQ_OP == FSRA_OP_PROGRAM) ? 3'd4 : 3'd3;
                            FL_ADDR <= cyc_addr(3'd0, REQ_OP, REQ_BASE, REQ_OFFSET);
                            FL_DQ_O <= cyc_data(3'd0, REQ_OP, REQ_WDATA);
                            FL_DQ_OE <= 1'b1;
                            FL_CE_N <= 1'b0;
                            state_reg <= FSRA_SETUP;
                        end
                    end
                end
                FSRA_SETUP: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= SETUP_CYC) begin
                        cnt_reg <= 8'h00;
                        FL_WE_N <= 1'b0;
                        state_reg <= FSRA_STROBE;
                    end
                end
                FSRA_STROBE: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= WE_LOW_CYC) begin
                        cnt_reg <= 8'h00;
                        FL_WE_N <= 1'b1;
                        state_reg <= FSRA_GAP;
                    end
                end
                FSRA_GAP: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= SETUP_CYC) begin
                        cnt_reg <= 8'h00;
                        if (cyc_reg + 3'd1 == ncyc_reg) begin
                            FL_DQ_OE <= 1'b0;
                            FL_CE_N <= 1'b1;
                            if (op_reg == FSRA_OP_ENTER) begin
                                IN_MODE <= 1'b1;
                            end else if (op_reg == FSRA_OP_EXIT) begin
                                IN_MODE <= 1'b0;
                            end
                            RSP_VALID <= 1'b1;
                            RSP_ERR <= 1'b0;
                            REQ_READY <= 1'b1;
                            state_reg <= FSRA_IDLE;
                        end else begin
                            cyc_reg <= cyc_reg + 3'd1;
                            FL_ADDR <= cyc_addr(cyc_reg + 3'd1, op_reg, base_reg, off_reg);
                            FL_DQ_O <= cyc_data(cyc_reg + 3'd1, op_reg, wdata_reg);
                            state_reg <= FSRA_SETUP;
                        end
                    end
                end
                FSRA_READ: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg >= READ_CYC + 8'd2 && dq_s2_reg == dq_s3_reg) begin
                        cnt_reg <= 8'h00;
                        FL_CE_N <= 1'b1;
                        FL_OE_N <= 1'b1;
                        RSP_RDATA <= dq_s3_reg;
                        if (op_reg == FSRA_OP_LOCKRD) begin
                            FACTORY_LOCK_INDICATOR <= dq_s3_reg[FACTORY_LOCK_BIT];
                            CUSTOMER_LOCK_INDICATOR <= dq_s3_reg[CUSTOMER_LOCK_BIT];
                        end
                        RSP_VALID <= 1'b1;
                        RSP_ERR <= 1'b0;
                        REQ_READY <= 1'b1;
                        state_reg <= FSRA_IDLE;
                    end
                end
                FSRA_RST: begin
                    FL_RESET_N <= 1'b0;
                    FL_CE_N <= 1'b1;
                    FL_WE_N <= 1'b1;
                    FL_OE_N <= 1'b1;
                    FL_DQ_OE <= 1'b0;
                    IN_MODE <= 1'b0;
                    REQ_READY <= 1'b0;
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= RESET_CYC) begin
                        cnt_reg <= 8'h00;
                        FL_RESET_N <= 1'b1;
                        state_reg <= FSRA_RECOVER;
                    end
                end
                FSRA_RECOVER: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg + 8'h01 >= RECOVER_CYC) begin
                        cnt_reg <= 8'h00;
                        REQ_READY <= 1'b1;
                        state_reg <= FSRA_IDLE;
                    end
                end
                default: state_reg <= FSRA_RST;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_enter_sets_mode: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && state_reg == FSRA_GAP && op_reg == FSRA_OP_ENTER && RSP_VALID == 1'b0
         && cyc_reg == 3'd2 && cnt_reg + 8'h01 >= SETUP_CYC) |=> IN_MODE)
        else $error("mode not entered");
    a_reset_clears_mode: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!FL_RESET_N) |-> ##1 !IN_MODE)
        else $error("mode survives reset");
    a_reset_min_width: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $fell(FL_RESET_N) |-> (!FL_RESET_N)[*3])
        else $error("reset pulse short");
    a_prog_factory_refused: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && req_take && prog_bad) |=> (RSP_VALID && RSP_ERR && FL_CE_N))
        else $error("bad program not refused");
    a_busy_refused: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLK_EN && req_take && busy_reg && REQ_OP != FSRA_OP_RESET) |=> RSP_ERR)
        else $error("access while busy");
    a_unlock_first: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == FSRA_STROBE && cyc_reg == 3'd0) |-> FL_DQ_O == UNLOCK_DATA1)
        else $error("wrong first unlock data");
    a_cmd_data: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_reg == FSRA_STROBE && cyc_reg == 3'd2 && op_reg == FSRA_OP_EXIT)
        |-> (FL_DQ_O == CMD_EXIT && FL_ADDR == base_reg + UNLOCK_ADDR1))
        else $error("wrong exit command");
    a_strobe_ctrl: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!FL_WE_N) |-> (!FL_CE_N && FL_OE_N && FL_DQ_OE))
        else $error("write strobe without bus drive");
    c_enter: cover property (@(posedge CORE_CLK) $rose(IN_MODE));
    c_program: cover property (@(posedge CORE_CLK) state_reg == FSRA_STROBE && cyc_reg == 3'd3);
    c_lockrd: cover property (@(posedge CORE_CLK) RSP_VALID && op_reg == FSRA_OP_LOCKRD);
endmodule

// [fsra_flash_model.sv]
// Behavioural flash device with the secured extra region, answering the host bus
`timescale 1ns/1ps
module fsra_flash_model
    import fsra_pkg::*;
#(
    parameter logic [ADDR_W-1:0] SECTOR0_LAST = 24'h000FFF,
    parameter int PROG_NS = 300
)(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] din,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic reset_n,
    input wire logic lock_set,
    input wire logic hold_busy,
    output logic [DATA_W-1:0] dout,
    output logic busy
);
    logic [DATA_W-1:0] region [0:255];
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] last_q = 16'h0000;
    logic [1:0] step = 2'd0;
    logic armed = 1'b0;
    logic in_region = 1'b0;
    logic id_mode = 1'b0;
    logic prog_busy = 1'b0;
    logic cust_locked = 1'b0;
    logic is_555;
    initial begin
        for (int i = 0; i < 256; i++) begin
            region[i] = (i < 128) ? 16'(16'hF000 + i) : 16'hFFFF;
        end
    end
    assign busy = prog_busy | hold_busy;
    assign is_555 = (addr[10:0] == 11'h555);
    always @(posedge lock_set) cust_locked = 1'b1;
    always @(negedge reset_n) begin
        {step, armed, in_region, id_mode, prog_busy} = '0;
    end
    // Command decoder, clocked by the rising write strobe
    always @(posedge we_n) begin
        if (!ce_n && reset_n && !busy) begin
            if (armed) begin
                armed = 1'b0;
                prog_busy = 1'b1;
                prog_busy <= #(PROG_NS) 1'b0;
                if (in_region && addr <= REGION_LAST && addr[7] && !cust_locked) begin
                    region[addr[7:0]] = din;
                end
            end else if (step == 2'd0) begin
                step = (is_555 && din == UNLOCK_DATA1) ? 2'd1 : 2'd0;
            end else if (step == 2'd1) begin
                step = (addr[10:0] == 11'h2AA && din == UNLOCK_DATA2) ? 2'd2 : 2'd0;
            end else begin
                step = 2'd0;
                if (is_555 && din == CMD_ENTER) in_region = 1'b1;
                else if (is_555 && din == CMD_EXIT && in_region) in_region = 1'b0;
                else if (is_555 && din == CMD_EXIT) id_mode = 1'b1;
                else if (is_555 && din == CMD_PROGRAM) armed = 1'b1;
            end
            if (din == 16'h00F0) begin
                step = 2'd0;
                id_mode = 1'b0;
            end
        end
    end
    // Read data; a released bus shows the inverse of its last value
    always @(*) begin
        if (in_region && addr <= REGION_LAST) rd = region[addr[7:0]];
        else if (in_region && addr <= SECTOR0_LAST) rd = ~last_q;
        // Lock indicator word answers at the id address whenever the region is not mapped in
        else if ((id_mode || !in_region) && addr == ID_LOCK_ADDR) rd = {8'h00, 1'b1, cust_locked, 6'h00};
        else rd = {addr[7:0], ~addr[7:0]};
    end
    always @(posedge oe_n or posedge ce_n) last_q = rd;
    assign dout = (!ce_n && !oe_n && we_n && reset_n) ? rd : ~last_q;
endmodule

// [fsra_testbench.sv]
// Self-checking bench for the secured extra region host controller
`timescale 1ns/1ps
module testbench;
    import fsra_pkg::*;
    typedef struct packed {
        fsra_op_t op; logic [7:0] off; logic [15:0] wd; logic err; logic chk; logic [15:0] rd;
        logic mode;
    } fsra_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    fsra_op_t req_op = FSRA_OP_READ;
    logic [7:0] req_off = 8'h00;
    logic [DATA_W-1:0] req_wd = 16'h0000;
    logic [ADDR_W-1:0] req_base = 24'h000000;
    logic [DATA_W-1:0] rsp_rdata, fl_dq_o, fl_dq_i, dev_q;
    logic [ADDR_W-1:0] fl_addr;
    logic busy, req_ready, rsp_valid, rsp_err, in_mode, fac_ind, cus_ind, fl_dq_oe;
    logic fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n;
    logic lock_set = 1'b0;
    logic hold_busy = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    fsra_row_t rows [13] = '{
        '{FSRA_OP_READ, 8'h10, 16'h0000, 1'b0, 1'b1, 16'h10EF, 1'b0},
        '{FSRA_OP_PROGRAM, 8'h80, 16'h1111, 1'b1, 1'b0, 16'h0000, 1'b0},
        '{FSRA_OP_LOCKRD, 8'h03, 16'h0000, 1'b0, 1'b1, 16'h0080, 1'b0},
        '{FSRA_OP_ENTER, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b1},
        '{FSRA_OP_LOCKRD, 8'h03, 16'h0000, 1'b1, 1'b0, 16'h0000, 1'b1},
        '{FSRA_OP_READ, 8'h05, 16'h0000, 1'b0, 1'b1, 16'hF005, 1'b1},
        '{FSRA_OP_PROGRAM, 8'h7F, 16'h0000, 1'b1, 1'b0, 16'h0000, 1'b1},
        '{FSRA_OP_PROGRAM, 8'h80, 16'h1234, 1'b0, 1'b0, 16'h0000, 1'b1},
        '{FSRA_OP_READ, 8'h80, 16'h0000, 1'b0, 1'b1, 16'h1234, 1'b1},
        '{FSRA_OP_PROGRAM, 8'hFF, 16'hABCD, 1'b0, 1'b0, 16'h0000, 1'b1},
        '{FSRA_OP_READ, 8'hFF, 16'h0000, 1'b0, 1'b1, 16'hABCD, 1'b1},
        '{FSRA_OP_EXIT, 8'h00, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0},
        '{FSRA_OP_READ, 8'h80, 16'h0000, 1'b0, 1'b1, 16'h807F, 1'b0}
    };
    always #5 core_clk = ~core_clk;
    assign fl_dq_i = fl_dq_oe ? fl_dq_o : dev_q;
    fsra_host u_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .CLK_EN(clk_en), .REQ_VALID(req_valid),
        .REQ_OP(req_op), .REQ_OFFSET(req_off), .REQ_WDATA(req_wd), .REQ_BASE(req_base),
        .FLASH_BUSY(busy), .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RSP_ERR(rsp_err), .IN_MODE(in_mode), .FACTORY_LOCK_INDICATOR(fac_ind),
        .CUSTOMER_LOCK_INDICATOR(cus_ind), .FL_ADDR(fl_addr), .FL_DQ_O(fl_dq_o),
        .FL_DQ_OE(fl_dq_oe), .FL_DQ_I(fl_dq_i), .FL_CE_N(fl_ce_n), .FL_WE_N(fl_we_n),
        .FL_OE_N(fl_oe_n), .FL_RESET_N(fl_reset_n));
    fsra_flash_model u_flash (.addr(fl_addr), .din(fl_dq_o), .ce_n(fl_ce_n), .we_n(fl_we_n),
        .oe_n(fl_oe_n), .reset_n(fl_reset_n), .lock_set(lock_set), .hold_busy(hold_busy),
        .dout(dev_q), .busy(busy));
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_req(input fsra_op_t op, input logic [7:0] off, input logic [15:0] wd,
                          input bit idle);
        int n;
        int i;
        n = 0;
        for (i = 0; i < 2000 && n < 4; i++) begin
            @(negedge core_clk);
            n = (req_ready === 1'b1 && (!idle || busy === 1'b0)) ? n + 1 : 0;
        end
        if (n < 4) begin
            n_mismatch++;
            print_verdict();
        end
        @(posedge core_clk);
        req_op <= op;
        req_off <= off;
        req_wd <= wd;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        i = 0;
        while (op != FSRA_OP_RESET && i < 400) begin
            @(negedge core_clk);
            i = (rsp_valid === 1'b1) ? 1000 : i + 1;
        end
        if (i == 400) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    initial begin
        repeat (2) @(negedge core_clk);
        chk("ready_in_reset", {15'h0, req_ready}, 16'h0000);
        chk("flash_reset", {15'h0, fl_reset_n}, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            do_req(rows[k].op, rows[k].off, rows[k].wd, 1'b1);
            chk("err", {15'h0, rsp_err}, {15'h0, rows[k].err});
            if (rows[k].chk) chk("rdata", rsp_rdata, rows[k].rd);
            chk("mode", {15'h0, in_mode}, {15'h0, rows[k].mode});
        end
        // Lock indicators before and after the customer half is locked
        for (int k = 0; k < 2; k++) begin
            lock_set = (k == 1);
            do_req(FSRA_OP_LOCKRD, 8'h03, 16'h0000, 1'b1);
            chk("factory_ind", {15'h0, fac_ind}, 16'h0001);
            chk("customer_ind", {15'h0, cus_ind}, 16'(k));
        end
        do_req(FSRA_OP_ENTER, 8'h00, 16'h0000, 1'b1);
        do_req(FSRA_OP_PROGRAM, 8'h81, 16'h5555, 1'b1);
        do_req(FSRA_OP_READ, 8'h81, 16'h0000, 1'b1);
        chk("locked_word", rsp_rdata, 16'hFFFF);
        do_req(FSRA_OP_RESET, 8'h00, 16'h0000, 1'b1);
        do_req(FSRA_OP_READ, 8'h81, 16'h0000, 1'b1);
        chk("mode_after_pin_reset", {15'h0, in_mode}, 16'h0000);
        chk("array_after_reset", rsp_rdata, 16'h817E);
        hold_busy = 1'b1;
        do_req(FSRA_OP_ENTER, 8'h00, 16'h0000, 1'b0);
        chk("busy_refused", {15'h0, rsp_err}, 16'h0001);
        chk("busy_no_select", {15'h0, fl_ce_n}, 16'h0001);
        hold_busy = 1'b0;
        do_req(FSRA_OP_ENTER, 8'h00, 16'h0000, 1'b1);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk("mode_in_reset", {15'h0, in_mode}, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        do_req(FSRA_OP_READ, 8'h05, 16'h0000, 1'b1);
        chk("array_after_rst", rsp_rdata, 16'h05FA);
        print_verdict();
    end
endmodule
